// ### dss_drive_state.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Read-only 16-bit status: bits 0-6 state flags, bit 7 warning, bit 10 target reached, bits 12/13 mode flags, others zero.
// - Bits 12/13 show mode-specific flags for position, homing, interpolation and velocity modes.
// - Not ready reads x0xx 0000; switch-on disabled reads x1xx 0000.
// - Ready x01x 0001, switched on x01x 0011, operation enabled x01x 0111.
// - Quick stop x00x 0111, fault reaction x0xx 1111, fault x0xx 1000.
// - Quick-stop option 0 removes torque and lets the motor coast.
// - Options 1 and 2 ramp quick or slow, then go to switch-on disabled.
// - Options 3 and 4 ramp quick or slow, then hold quick-stop with drive enabled.
// - Fault option 0 removes torque and lets the motor freewheel.
// - Fault options 1 and 2 ramp quick or slow, then enter fault.
// - Slow-stop time is unsigned 32-bit milliseconds, reset zero, sets slow ramp duration.
// - Control word 2 when enabled starts the configured quick stop.
module dss_drive_state #(
  parameter int MS_CYCLES = dss_pkg::MS_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        od_wr,
  input  wire logic        od_rd,
  input  wire logic [15:0] od_index,
  input  wire logic [31:0] od_wdata,
  output logic [31:0]      od_rdata_q,
  output logic             od_ack_q,
  output logic             od_err_q,
  input  wire logic        init_done,
  input  wire logic        fault_in,
  input  wire logic        warning_in,
  input  wire logic        target_reached,
  input  wire logic        motor_still,
  input  wire logic [7:0]  mode,
  input  wire logic        setpoint_ack,
  input  wire logic        follow_err,
  input  wire logic        homing_done,
  input  wire logic        homing_err,
  input  wire logic        interp_active,
  input  wire logic        zero_speed,
  output logic [15:0]      status_word_q,
  output logic             torque_en_q,
  output logic             decel_q,
  output logic             ramp_slow_q
);

  // Refuse a prescaler that cannot count a millisecond
  if (MS_CYCLES < 1) begin : g_bad_ms_cycles
    $error("MS_CYCLES must be at least 1");
  end

  dss_pkg::dss_state_e state_q, state_d;
  logic [15:0] cw_q, cw_d, qs_opt_q, qs_opt_d, fr_opt_q, fr_opt_d, status_d;
  logic [31:0] slow_ms_q, slow_ms_d, rdata_d;
  logic        stopped_q, stopped_d, torque_d, decel_d, slow_d, ack_d, err_d;
  logic        tmr_start, tmr_run, tmr_done;
  dss_pkg::dss_stop_e qs_kind, fr_kind, act_kind;
  logic        qs_hold, stop_now;
  logic        cmd_shutdown, cmd_swon, cmd_enable, cmd_disvolt, cmd_qstop, freset;

  // Control word command decode
  assign cmd_disvolt  = !cw_q[dss_pkg::CW_VOLT];
  assign cmd_qstop    = cw_q[dss_pkg::CW_VOLT] && !cw_q[dss_pkg::CW_QS_N];
  assign cmd_shutdown = cw_q[2:0] == 3'h6;
  assign cmd_swon     = cw_q[2:0] == 3'h7;
  assign cmd_enable   = cw_q[3:0] == 4'hf;
  assign freset       = od_wr && od_index == dss_pkg::OD_IDX_CTRL
                        && od_wdata[dss_pkg::CW_FRESET] && !cw_q[dss_pkg::CW_FRESET];

  // Reaction decode; reserved codes give coast
  assign qs_kind  = dss_pkg::stop_kind(qs_opt_q, 1'b1);
  assign fr_kind  = dss_pkg::stop_kind(fr_opt_q, 1'b0);
  assign qs_hold  = qs_opt_q == dss_pkg::OPT_QUICK_HOLD || qs_opt_q == dss_pkg::OPT_SLOW_HOLD;
  assign act_kind = (state_q == dss_pkg::FAULT_REACT) ? fr_kind : qs_kind;
  // Quick ramp ends at standstill; slow ramp ends when the set time elapses
  assign stop_now = (act_kind == dss_pkg::STOP_SLOW) ? tmr_done : motor_still;

  // Object-dictionary writes and reads
  always_comb begin
    cw_d      = cw_q;
    slow_ms_d = slow_ms_q;
    qs_opt_d  = qs_opt_q;
    fr_opt_d  = fr_opt_q;
    rdata_d   = od_rdata_q;
    ack_d     = od_wr || od_rd;
    err_d     = 1'b0;
    if (od_wr) begin
      case (od_index)
        dss_pkg::OD_IDX_CTRL:      cw_d = od_wdata[15:0];
        dss_pkg::OD_IDX_SLOW_TIME: slow_ms_d = od_wdata;
        dss_pkg::OD_IDX_QS_OPT:    qs_opt_d = od_wdata[15:0];
        dss_pkg::OD_IDX_FR_OPT:    fr_opt_d = od_wdata[15:0];
        default:                   err_d = 1'b1;
      endcase
    end else if (od_rd) begin
      case (od_index)
        dss_pkg::OD_IDX_CTRL:      rdata_d = {16'h0000, cw_q};
        dss_pkg::OD_IDX_STATUS:    rdata_d = {16'h0000, status_word_q};
        dss_pkg::OD_IDX_SLOW_TIME: rdata_d = slow_ms_q;
        dss_pkg::OD_IDX_QS_OPT:    rdata_d = {16'h0000, qs_opt_q};
        dss_pkg::OD_IDX_FR_OPT:    rdata_d = {16'h0000, fr_opt_q};
        default: begin
          rdata_d = 32'h0000_0000;
          err_d   = 1'b1;
        end
      endcase
    end
  end

  // Drive state machine; a fault overrides every command except fault reset in the fault state
  always_comb begin
    state_d = state_q;
    if (fault_in && state_q != dss_pkg::FAULT_REACT && state_q != dss_pkg::FAULT) begin
      state_d = dss_pkg::FAULT_REACT;
    end else begin
      case (state_q)
        dss_pkg::NOT_READY:   if (init_done) state_d = dss_pkg::SW_ON_DIS;
        dss_pkg::SW_ON_DIS:   if (cmd_shutdown) state_d = dss_pkg::READY;
        dss_pkg::READY: begin
          if (cmd_disvolt || cmd_qstop) state_d = dss_pkg::SW_ON_DIS;
          else if (cmd_swon) state_d = dss_pkg::SWITCHED_ON;
        end
        dss_pkg::SWITCHED_ON: begin
          if (cmd_disvolt || cmd_qstop) state_d = dss_pkg::SW_ON_DIS;
          else if (cmd_enable) state_d = dss_pkg::OP_ENABLED;
          else if (cmd_shutdown) state_d = dss_pkg::READY;
        end
        dss_pkg::OP_ENABLED: begin
          if (cmd_disvolt) state_d = dss_pkg::SW_ON_DIS;
          else if (cmd_qstop) state_d = dss_pkg::QS_ACTIVE;
          else if (cmd_shutdown) state_d = dss_pkg::READY;
          else if (cmd_swon && !cw_q[dss_pkg::CW_ENOP]) state_d = dss_pkg::SWITCHED_ON;
        end
        dss_pkg::QS_ACTIVE: begin
          if (cmd_disvolt || qs_kind == dss_pkg::STOP_COAST) state_d = dss_pkg::SW_ON_DIS;
          else if (!qs_hold && (stopped_q || stop_now)) state_d = dss_pkg::SW_ON_DIS;
          else if (qs_hold && stopped_q && cmd_enable) state_d = dss_pkg::OP_ENABLED;
        end
        dss_pkg::FAULT_REACT: begin
          if (fr_kind == dss_pkg::STOP_COAST) state_d = dss_pkg::FAULT;
          else if (stopped_q || stop_now) state_d = dss_pkg::FAULT;
        end
        dss_pkg::FAULT:       if (freset) state_d = dss_pkg::SW_ON_DIS;
        default:              state_d = dss_pkg::NOT_READY;
      endcase
    end
  end

  // Ramp timer runs while a stop is in progress
  assign tmr_start = state_d != state_q;
  assign tmr_run   = state_q == dss_pkg::QS_ACTIVE || state_q == dss_pkg::FAULT_REACT;

  dss_ramp_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_ramp_timer (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .start    (tmr_start),
    .run      (tmr_run),
    .limit_ms (slow_ms_q),
    .done_q   (tmr_done)
  );

  // Torque, ramp selection and status word from the next state
  always_comb begin
    dss_pkg::dss_stop_e nk;
    nk        = (state_d == dss_pkg::FAULT_REACT) ? fr_kind : qs_kind;
    stopped_d = (state_d == state_q) && tmr_run && (stopped_q || stop_now);
    torque_d  = 1'b0;
    if (state_d == dss_pkg::OP_ENABLED) torque_d = 1'b1;
    else if (state_d == dss_pkg::QS_ACTIVE || state_d == dss_pkg::FAULT_REACT)
      torque_d = nk != dss_pkg::STOP_COAST;
    decel_d   = torque_d && state_d != dss_pkg::OP_ENABLED && !stopped_d;
    slow_d    = decel_d && nk == dss_pkg::STOP_SLOW;
    status_d  = 16'h0000;
    case (state_d)
      dss_pkg::NOT_READY:   status_d[7:0] = 8'h00;
      dss_pkg::SW_ON_DIS:   status_d[7:0] = 8'h40;
      dss_pkg::READY:       status_d[7:0] = 8'h31;
      dss_pkg::SWITCHED_ON: status_d[7:0] = 8'h33;
      dss_pkg::OP_ENABLED:  status_d[7:0] = 8'h37;
      dss_pkg::QS_ACTIVE:   status_d[7:0] = 8'h17;
      dss_pkg::FAULT_REACT: status_d[7:0] = 8'h0f;
      dss_pkg::FAULT:       status_d[7:0] = 8'h08;
      default:              status_d[7:0] = 8'h00;
    endcase
    status_d[dss_pkg::ST_WARN]   = warning_in;
    status_d[dss_pkg::ST_TARGET] = target_reached;
    case (mode)
      dss_pkg::MODE_PP: status_d[13:12] = {follow_err, setpoint_ack};
      dss_pkg::MODE_HM: status_d[13:12] = {homing_err, homing_done};
      dss_pkg::MODE_IP: status_d[13:12] = {1'b0, interp_active};
      dss_pkg::MODE_PV: status_d[13:12] = {1'b0, zero_speed};
      default:          status_d[13:12] = 2'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= dss_pkg::NOT_READY;
      cw_q          <= dss_pkg::CTRL_RST;
      slow_ms_q     <= dss_pkg::SLOW_TIME_RST;
      qs_opt_q      <= dss_pkg::QS_OPT_RST;
      fr_opt_q      <= dss_pkg::FR_OPT_RST;
      stopped_q     <= 1'b0;
      status_word_q <= 16'h0000;
      torque_en_q   <= 1'b0;
      decel_q       <= 1'b0;
      ramp_slow_q   <= 1'b0;
      od_rdata_q    <= 32'h0000_0000;
      od_ack_q      <= 1'b0;
      od_err_q      <= 1'b0;
    end else if (ce) begin
      state_q       <= state_d;
      cw_q          <= cw_d;
      slow_ms_q     <= slow_ms_d;
      qs_opt_q      <= qs_opt_d;
      fr_opt_q      <= fr_opt_d;
      stopped_q     <= stopped_d;
      status_word_q <= status_d;
      torque_en_q   <= torque_d;
      decel_q       <= decel_d;
      ramp_slow_q   <= slow_d;
      od_rdata_q    <= rdata_d;
      od_ack_q      <= ack_d;
      od_err_q      <= err_d;
    end
  end

  // Checks
  default clocking dss_cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_qs_request;
    ce && state_q == dss_pkg::OP_ENABLED && cmd_qstop && !fault_in;
  endsequence

  sequence s_fault_coast;
    ce && state_q == dss_pkg::FAULT_REACT && fr_kind == dss_pkg::STOP_COAST;
  endsequence

  AST_UNUSED_BITS: assert property (
    status_word_q[9:8] == 2'h0 && status_word_q[11] == 1'b0 && status_word_q[15:14] == 2'h0)
    else $error("Unused status bits not zero");
  AST_MODE_PP: assert property (
    ce && mode == dss_pkg::MODE_PP |=> status_word_q[13:12] == {$past(follow_err), $past(setpoint_ack)})
    else $error("Profile position mode bits wrong");
  AST_SOD_PATTERN: assert property (
    state_q == dss_pkg::SW_ON_DIS |-> status_word_q[6] && status_word_q[3:0] == 4'h0 && !torque_en_q)
    else $error("Switch-on disabled pattern wrong");
  AST_OPEN_PATTERN: assert property (
    state_q == dss_pkg::OP_ENABLED |-> status_word_q[6:5] == 2'h1 && status_word_q[3:0] == 4'h7 && torque_en_q)
    else $error("Operation enabled pattern wrong");
  AST_FAULT_PATTERN: assert property (
    state_q == dss_pkg::FAULT |-> !status_word_q[6] && status_word_q[3:0] == 4'h8 && !torque_en_q)
    else $error("Fault pattern wrong");
  AST_QS_ENTRY: assert property (
    s_qs_request |=> state_q == dss_pkg::QS_ACTIVE && status_word_q[6:5] == 2'h0 && status_word_q[3:0] == 4'h7)
    else $error("Quick stop not entered");
  AST_QS_COAST: assert property (
    ce && state_q == dss_pkg::QS_ACTIVE && qs_opt_q == dss_pkg::OPT_COAST && !fault_in
    |=> state_q == dss_pkg::SW_ON_DIS && !torque_en_q)
    else $error("Coast quick stop did not release torque");
  AST_QS_RESERVED: assert property (
    ce && state_q == dss_pkg::QS_ACTIVE && qs_opt_q > dss_pkg::OPT_SLOW_HOLD && !fault_in
    |=> state_q == dss_pkg::SW_ON_DIS)
    else $error("Reserved quick stop option not coasting");
  AST_QS_HOLD: assert property (
    ce && state_q == dss_pkg::QS_ACTIVE && qs_hold && stopped_q && !cmd_disvolt && !cmd_enable && !fault_in
    |=> state_q == dss_pkg::QS_ACTIVE && torque_en_q && !decel_q)
    else $error("Hold option left quick stop");
  AST_FAULT_COAST: assert property (
    s_fault_coast |=> state_q == dss_pkg::FAULT && !torque_en_q)
    else $error("Freewheel fault reaction wrong");
  AST_SLOW_TIME: assert property (
    ce && od_wr && od_index == dss_pkg::OD_IDX_SLOW_TIME |=> slow_ms_q == $past(od_wdata))
    else $error("Slow stop time not stored");

endmodule // dss_drive_state

// ### dss_pkg.sv
package dss_pkg;

  // Object indexes on the object-dictionary port
  localparam logic [15:0] OD_IDX_CTRL      = 16'h6040;
  localparam logic [15:0] OD_IDX_STATUS    = 16'h6041;
  localparam logic [15:0] OD_IDX_SLOW_TIME = 16'h6050;
  localparam logic [15:0] OD_IDX_QS_OPT    = 16'h605a;
  localparam logic [15:0] OD_IDX_FR_OPT    = 16'h605e;

  // Reset values
  localparam logic [15:0] CTRL_RST      = 16'h0000;
  localparam logic [31:0] SLOW_TIME_RST = 32'h0000_0000;
  localparam logic [15:0] QS_OPT_RST    = 16'h0000;
  localparam logic [15:0] FR_OPT_RST    = 16'h0000;

  // Status word bit positions
  localparam int ST_RTSO   = 0;
  localparam int ST_SWON   = 1;
  localparam int ST_OPEN   = 2;
  localparam int ST_FAULT  = 3;
  localparam int ST_VOLT   = 4;
  localparam int ST_QS     = 5;
  localparam int ST_SOD    = 6;
  localparam int ST_WARN   = 7;
  localparam int ST_TARGET = 10;
  localparam int ST_MODE_A = 12;
  localparam int ST_MODE_B = 13;

  // Control word bit positions
  localparam int CW_SWON   = 0;
  localparam int CW_VOLT   = 1;
  localparam int CW_QS_N   = 2;
  localparam int CW_ENOP   = 3;
  localparam int CW_FRESET = 7;

  // Operating mode codes
  localparam logic [7:0] MODE_PP = 8'h01;
  localparam logic [7:0] MODE_PV = 8'h03;
  localparam logic [7:0] MODE_HM = 8'h06;
  localparam logic [7:0] MODE_IP = 8'h07;

  // Stop option codes
  localparam logic [15:0] OPT_COAST      = 16'h0000;
  localparam logic [15:0] OPT_QUICK      = 16'h0001;
  localparam logic [15:0] OPT_SLOW       = 16'h0002;
  localparam logic [15:0] OPT_QUICK_HOLD = 16'h0003;
  localparam logic [15:0] OPT_SLOW_HOLD  = 16'h0004;

  // Timing
  localparam int MS_NS     = 1000000;
  localparam int CLK_NS    = 20;
  localparam int MS_CYCLES = MS_NS / CLK_NS;

  typedef enum logic [2:0] {
    NOT_READY, SW_ON_DIS, READY, SWITCHED_ON, OP_ENABLED, QS_ACTIVE, FAULT_REACT, FAULT
  } dss_state_e;

  typedef enum logic [1:0] {STOP_COAST, STOP_QUICK, STOP_SLOW} dss_stop_e;

  // Ramp kind for an option; hold codes only legal when allowed, else coast
  function automatic dss_stop_e stop_kind(input logic [15:0] opt, input logic hold_ok);
    case (opt)
      OPT_QUICK:      stop_kind = STOP_QUICK;
      OPT_SLOW:       stop_kind = STOP_SLOW;
      OPT_QUICK_HOLD: stop_kind = hold_ok ? STOP_QUICK : STOP_COAST;
      OPT_SLOW_HOLD:  stop_kind = hold_ok ? STOP_SLOW : STOP_COAST;
      default:        stop_kind = STOP_COAST;
    endcase
  endfunction

endpackage

// ### dss_ramp_timer.sv
`timescale 1ns/1ns
// Times a slow-ramp stop in milliseconds
module dss_ramp_timer #(
  parameter int MS_CYCLES = dss_pkg::MS_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic        run,
  input  wire logic [31:0] limit_ms,
  output logic             done_q
);

  localparam int PW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;

  // Refuse a prescaler that cannot count a millisecond
  if (MS_CYCLES < 1) begin : g_bad_ms_cycles
    $error("MS_CYCLES must be at least 1");
  end

  logic [PW-1:0] pre_q, pre_d;
  logic [31:0]   ms_q, ms_d;
  logic          done_d;

  // Millisecond prescaler and elapsed count
  always_comb begin
    pre_d  = pre_q;
    ms_d   = ms_q;
    done_d = 1'b0;
    if (start || !run) begin
      pre_d = '0;
      ms_d  = 32'h0000_0000;
    end else begin
      done_d = (ms_q >= limit_ms);
      if (pre_q == PW'(MS_CYCLES - 1)) begin
        pre_d = '0;
        if (ms_q != 32'hffff_ffff) ms_d = ms_q + 32'h0000_0001;
      end else begin
        pre_d = pre_q + PW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q  <= '0;
      ms_q   <= 32'h0000_0000;
      done_q <= 1'b0;
    end else if (ce) begin
      pre_q  <= pre_d;
      ms_q   <= ms_d;
      done_q <= done_d;
    end
  end

endmodule // dss_ramp_timer

// ### dss_master_model.sv
`timescale 1ns/1ns
// Fieldbus master: issues object reads and writes on the drive's object port
module dss_master_model (
  input  wire logic        clk,
  input  wire logic        od_ack_q,
  input  wire logic        od_err_q,
  input  wire logic [31:0] od_rdata_q,
  output logic             od_wr,
  output logic             od_rd,
  output logic [15:0]      od_index,
  output logic [31:0]      od_wdata
);
  // Idle bus with no strobe
  initial begin
    od_wr    = 1'b0;
    od_rd    = 1'b0;
    od_index = 16'h0000;
    od_wdata = 32'h0000_0000;
  end

  // One access: strobe for one cycle, then a bounded wait for the answer
  task automatic access(input logic wr, input logic [15:0] idx, input logic [31:0] data,
                        output logic [31:0] rdata, output logic err, output logic ok);
    int n;
    rdata = 32'h0000_0000;
    err   = 1'b0;
    ok    = 1'b0;
    @(posedge clk);
    #1;
    od_wr    = wr;
    od_rd    = ~wr;
    od_index = idx;
    od_wdata = data;
    @(posedge clk);
    #1;
    od_wr    = 1'b0;
    od_rd    = 1'b0;
    od_wdata = ~data; // Stale data must not be mistaken for a live write
    for (n = 0; n < 4; n++) begin
      if (!ok) begin
        if (od_ack_q === 1'b1) begin
          ok    = 1'b1;
          rdata = od_rdata_q;
          err   = od_err_q;
        end else begin
          @(posedge clk);
          #1;
        end
      end
    end
  endtask
endmodule // dss_master_model

// ### tb.sv
`timescale 1ns/1ns
// Drive state and stop-reaction bench
module tb;
  logic        clk;
  logic        rst_n;
  logic        ce;
  logic        init_done;
  logic        fault_in;
  logic        warning_in;
  logic        target_reached;
  logic        motor_still;
  logic [7:0]  mode;
  logic [5:0]  aux;
  logic        od_wr;
  logic        od_rd;
  logic [15:0] od_index;
  logic [31:0] od_wdata;
  logic [31:0] od_rdata_q;
  logic        od_ack_q;
  logic        od_err_q;
  logic [15:0] status_word_q;
  logic        torque_en_q;
  logic        decel_q;
  logic        ramp_slow_q;
  int          mismatches;
  int          compares;
  int          i;
  logic [7:0]  modes [4];
  logic [1:0]  mbits [4];

  dss_drive_state #(.MS_CYCLES(5)) u_dss_drive_state (
    .clk(clk), .rst_n(rst_n), .ce(ce), .od_wr(od_wr), .od_rd(od_rd), .od_index(od_index),
    .od_wdata(od_wdata), .od_rdata_q(od_rdata_q), .od_ack_q(od_ack_q), .od_err_q(od_err_q),
    .init_done(init_done), .fault_in(fault_in), .warning_in(warning_in),
    .target_reached(target_reached), .motor_still(motor_still), .mode(mode),
    .setpoint_ack(aux[0]), .follow_err(aux[1]), .homing_done(aux[2]), .homing_err(aux[3]),
    .interp_active(aux[4]), .zero_speed(aux[5]), .status_word_q(status_word_q),
    .torque_en_q(torque_en_q), .decel_q(decel_q), .ramp_slow_q(ramp_slow_q));

  dss_master_model u_dss_master_model (
    .clk(clk), .od_ack_q(od_ack_q), .od_err_q(od_err_q), .od_rdata_q(od_rdata_q),
    .od_wr(od_wr), .od_rd(od_rd), .od_index(od_index), .od_wdata(od_wdata));

  // 50 MHz clock
  always #10 clk = ~clk;

  task automatic end_of_test();
    if (mismatches == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] data, input logic exp_err);
    logic [31:0] rd;
    logic        e;
    logic        ok;
    u_dss_master_model.access(1'b1, idx, data, rd, e, ok);
    check("ack", 32'h1, {31'h0, ok});
    check("err", {31'h0, exp_err}, {31'h0, e});
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        e;
    logic        ok;
    u_dss_master_model.access(1'b0, idx, 32'h0000_0000, rd, e, ok);
    check("ack", 32'h1, {31'h0, ok});
    check("err", {31'h0, exp_err}, {31'h0, e});
    check("rdata", exp, rd);
  endtask

  // Bounded wait for a status value, then compare
  task automatic wait_st(input logic [15:0] exp);
    int n;
    for (n = 0; n < 60 && status_word_q !== exp; n++) begin
      step(1);
    end
    check("status", {16'h0, exp}, {16'h0, status_word_q});
  endtask

  task automatic enable();
    wr(dss_pkg::OD_IDX_CTRL, 32'h6, 1'b0);
    wait_st(16'h0031);
    wr(dss_pkg::OD_IDX_CTRL, 32'h7, 1'b0);
    wait_st(16'h0033);
    wr(dss_pkg::OD_IDX_CTRL, 32'hf, 1'b0);
    wait_st(16'h0037);
    check("torque", 32'h1, {31'h0, torque_en_q});
  endtask

  // Watchdog over the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    init_done = 1'b0;
    fault_in = 1'b0;
    warning_in = 1'b0;
    target_reached = 1'b0;
    motor_still = 1'b0;
    mode = dss_pkg::MODE_PP;
    aux = 6'h00;
    mismatches = 0;
    compares = 0;
    modes = '{dss_pkg::MODE_PP, dss_pkg::MODE_HM, dss_pkg::MODE_IP, dss_pkg::MODE_PV};
    mbits = '{2'b11, 2'b11, 2'b01, 2'b01};
    step(8);
    rst_n = 1'b1;
    wait_st(16'h0000);
    rd_chk(dss_pkg::OD_IDX_STATUS, 32'h0, 1'b0);
    rd_chk(dss_pkg::OD_IDX_SLOW_TIME, 32'h0, 1'b0);
    rd_chk(dss_pkg::OD_IDX_QS_OPT, 32'h0, 1'b0);
    rd_chk(dss_pkg::OD_IDX_FR_OPT, 32'h0, 1'b0);
    wr(dss_pkg::OD_IDX_STATUS, 32'hffff, 1'b1);
    rd_chk(16'h6042, 32'h0, 1'b1);
    init_done = 1'b1;
    wait_st(16'h0040);
    // Clock enable low freezes the status word
    ce = 1'b0;
    warning_in = 1'b1;
    step(3);
    check("frozen_status", 32'h0000_0040, {16'h0, status_word_q});
    ce = 1'b1;
    // Mode-specific bits with every flag input high
    aux = 6'h3f;
    warning_in = 1'b1;
    target_reached = 1'b1;
    for (i = 0; i < 4; i++) begin
      mode = modes[i];
      wait_st({2'b00, mbits[i], 4'h4, 8'hc0});
      rd_chk(dss_pkg::OD_IDX_STATUS, {18'h0, mbits[i], 4'h4, 8'hc0}, 1'b0);
    end
    aux = 6'h00;
    warning_in = 1'b0;
    target_reached = 1'b0;
    mode = dss_pkg::MODE_PP;
    wr(dss_pkg::OD_IDX_SLOW_TIME, 32'h89ab_cdef, 1'b0);
    rd_chk(dss_pkg::OD_IDX_SLOW_TIME, 32'h89ab_cdef, 1'b0);
    wr(dss_pkg::OD_IDX_SLOW_TIME, 32'h2, 1'b0);
    // Quick-stop reactions, reserved code included
    for (i = 0; i < 6; i++) begin
      enable();
      wr(dss_pkg::OD_IDX_QS_OPT, i, 1'b0);
      wr(dss_pkg::OD_IDX_CTRL, 32'h2, 1'b0);
      if (i == 0 || i == 5) begin
        wait_st(16'h0040);
        check("torque", 32'h0, {31'h0, torque_en_q});
      end else begin
        wait_st(16'h0017);
        step(8);
        check("decel", 32'h1, {31'h0, decel_q});
        check("ramp_slow", {31'h0, i[0] == 1'b0}, {31'h0, ramp_slow_q});
        motor_still = i[0];
        for (int n = 0; n < 20 && decel_q !== 1'b0; n++) begin
          step(1);
        end
        motor_still = 1'b0;
        wait_st((i < 3) ? 16'h0040 : 16'h0017);
        check("torque", {31'h0, i >= 3}, {31'h0, torque_en_q});
        if (i >= 3) begin
          wr(dss_pkg::OD_IDX_CTRL, 32'hf, 1'b0);
          wait_st(16'h0037);
        end
      end
    end
    // Fault reactions, reserved code included
    for (i = 0; i < 4; i++) begin
      enable();
      wr(dss_pkg::OD_IDX_FR_OPT, i, 1'b0);
      fault_in = 1'b1;
      if (i == 1 || i == 2) begin
        wait_st(16'h000f);
        check("decel", 32'h1, {31'h0, decel_q});
        check("ramp_slow", {31'h0, i == 2}, {31'h0, ramp_slow_q});
        motor_still = (i == 1);
      end
      wait_st(16'h0008);
      check("torque", 32'h0, {31'h0, torque_en_q});
      motor_still = 1'b0;
      fault_in = 1'b0;
      wr(dss_pkg::OD_IDX_CTRL, 32'h80, 1'b0);
      wait_st(16'h0040);
    end
    end_of_test();
  end
endmodule // tb
